/* rtl/pcipm_defines.svh */
`ifndef PCIPM_DEFINES_SVH
`define PCIPM_DEFINES_SVH

// ============================================================
// Register byte offsets in configuration space
// ============================================================
`define PCIPM_OFS_BUS_REQ      8'h3c
`define PCIPM_OFS_PM_CAP       8'hdc
`define PCIPM_OFS_PM_CSR       8'he0

// ============================================================
// Bus requirements word fields
// ============================================================
`define PCIPM_INT_PIN_VALUE    8'h01
`define PCIPM_INT_LINE_RESET   8'h00
`define PCIPM_HINT_RESET       8'h00
`define PCIPM_BYTE_INT_LINE    0

// ============================================================
// Capabilities word fields
// ============================================================
`define PCIPM_CAP_WAKE_STATES  4'he
`define PCIPM_CAP_D2_D1        2'h3
`define PCIPM_CAP_RESERVED     3'h0
`define PCIPM_CAP_DEV_INIT     1'h1
`define PCIPM_CAP_WAKE_CLOCK   1'h0
`define PCIPM_CAP_VERSION      3'h1
`define PCIPM_CAP_NEXT_PTR     8'h00
`define PCIPM_CAP_ID           8'h01

// ============================================================
// Control/status word fields
// ============================================================
`define PCIPM_CSR_POWER_DATA   8'h00
`define PCIPM_CSR_BRIDGE_EXT   8'h00
`define PCIPM_CSR_REPORT_SCALE 2'h0
`define PCIPM_CSR_REPORT_SEL   4'h0
`define PCIPM_CSR_RESERVED     6'h00
`define PCIPM_CSR_FLAG_BIT     15
`define PCIPM_CSR_ENABLE_BIT   8
`define PCIPM_CSR_STATE_LSB    0
`define PCIPM_BYTE_CSR_LOW     0
`define PCIPM_BYTE_CSR_HIGH    1

// ============================================================
// Strap capture timing
// ============================================================
`define PCIPM_STRAP_SETTLE     2'h2

`endif

/* rtl/pcipm_pkg.sv */
package pcipm_pkg;

	// ============================================================
	// Power states
	// ============================================================
	typedef enum logic [1:0] {
		PCIPM_D0 = 2'h0,
		PCIPM_D1 = 2'h1,
		PCIPM_D2 = 2'h2,
		PCIPM_D3 = 2'h3
	} pcipm_power_state_t;

	// ============================================================
	// Configuration access carriers
	// ============================================================
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  addr;
		logic [3:0]  byteEn;
		logic [31:0] data;
	} pcipm_cfg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} pcipm_cfg_rsp_t;

	typedef struct packed {
		logic       load;
		logic [7:0] maxLatency;
		logic [7:0] minGrant;
	} pcipm_hint_load_t;

endpackage

/* rtl/pcipm_strap_latch.sv */
`timescale 1ns/1ps
`include "pcipm_defines.svh"

module pcipm_strap_latch (
	// Clock and power-on reset
	input  wire logic clock,
	input  wire logic powerOnRst,
	// Board pin
	input  wire logic board_aux_power_strap,
	// Latched level
	output logic      strapLatched
);

	// ============================================================
	// Two-stage synchroniser and one-time capture
	// ============================================================
	logic       syncFirst;
	logic       syncSecond;
	logic [1:0] settleCnt;
	logic       captured;
	logic [1:0] next_settleCnt;
	logic       next_captured;
	logic       next_strapLatched;

	always_comb begin
		next_settleCnt    = settleCnt;
		next_captured     = captured;
		next_strapLatched = strapLatched;
		if (!captured) begin
			if (settleCnt == `PCIPM_STRAP_SETTLE) begin
				next_captured     = 1'b1;
				next_strapLatched = syncSecond;
			end else begin
				next_settleCnt = settleCnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		syncFirst  <= board_aux_power_strap;
		syncSecond <= syncFirst;
		if (powerOnRst) begin
			settleCnt    <= 2'h0;
			captured     <= 1'b0;
			strapLatched <= 1'b0;
		end else begin
			settleCnt    <= next_settleCnt;
			captured     <= next_captured;
			strapLatched <= next_strapLatched;
		end
	end

endmodule

/* rtl/pcipm_wake_flag.sv */
`timescale 1ns/1ps
`include "pcipm_defines.svh"

module pcipm_wake_flag (
	// Clock and resets
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic powerOnRst,
	// Event and host controls
	input  wire logic wakeDetect,
	input  wire logic flagClear,
	input  wire logic enableWrite,
	input  wire logic enableData,
	// State and output
	output logic      wake_event_flag,
	output logic      wake_notify_enable,
	output logic      wakeOut
);

	// ============================================================
	// Sticky flag, enable and gated wake output
	// ============================================================
	logic next_flag;
	logic next_enable;
	logic next_wakeOut;

	always_comb begin
		next_flag = wake_event_flag;
		if (flagClear) begin
			next_flag = 1'b0;
		end
		if (wakeDetect) begin
			next_flag = 1'b1;
		end
		next_enable = enableWrite ? enableData : wake_notify_enable;
		if (sys_rst) begin
			next_enable = 1'b0;
		end
		next_wakeOut = next_flag & next_enable;
	end

	always_ff @(posedge clock) begin
		if (powerOnRst) begin
			wake_event_flag    <= 1'b0;
			wake_notify_enable <= 1'b0;
			wakeOut            <= 1'b0;
		end else begin
			wake_event_flag    <= next_flag;
			wake_notify_enable <= next_enable;
			wakeOut            <= next_wakeOut;
		end
	end

endmodule

/* rtl/pcipm_config_regs.sv */
`timescale 1ns/1ps
`include "pcipm_defines.svh"

module pcipm_config_regs #(
	parameter int HINT_WIDTH = 8
) (
	// Clock and resets
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic                      powerOnRst,
	// Configuration access
	input  wire pcipm_pkg::pcipm_cfg_req_t cfgReq,
	output pcipm_pkg::pcipm_cfg_rsp_t      cfgRsp,
	// Hint values from the serial configuration memory loader
	input  wire pcipm_pkg::pcipm_hint_load_t hintLoad,
	// Board strap and wake events
	input  wire logic                      board_aux_power_strap,
	input  wire logic                      wakeDetect,
	// Status outputs
	output logic                           wakeOut,
	output pcipm_pkg::pcipm_power_state_t  powerState
);

	// ============================================================
	// Elaboration check
	// ============================================================
	if (HINT_WIDTH != 8) begin : gBadWidth
		$error("HINT_WIDTH must be 8");
	end

	// ============================================================
	// Address decode
	// ============================================================
	logic hitBusReq;
	logic hitPmCap;
	logic hitPmCsr;
	logic wrBusReq;
	logic wrPmCsr;

	// Address bits 1 and 0 are ignored, since the byte lanes come from byteEn.
	always_comb begin
		hitBusReq = {cfgReq.addr[7:2], 2'h0} == `PCIPM_OFS_BUS_REQ;
		hitPmCap  = {cfgReq.addr[7:2], 2'h0} == `PCIPM_OFS_PM_CAP;
		hitPmCsr  = {cfgReq.addr[7:2], 2'h0} == `PCIPM_OFS_PM_CSR;
		wrBusReq  = cfgReq.write & hitBusReq;
		wrPmCsr   = cfgReq.write & hitPmCsr;
	end

	// ============================================================
	// Strap capture and wake flag
	// ============================================================
	logic strapLatched;
	logic wakeFlag;
	logic wakeEnable;
	logic lowPower;
	logic flagClear;
	logic enableWrite;

	pcipm_strap_latch uStrap (
		.clock                 (clock),
		.powerOnRst            (powerOnRst),
		.board_aux_power_strap (board_aux_power_strap),
		.strapLatched          (strapLatched)
	);

	always_comb begin
		lowPower    = powerState != pcipm_pkg::PCIPM_D0;
		flagClear   = wrPmCsr & cfgReq.byteEn[`PCIPM_BYTE_CSR_HIGH]
		              & cfgReq.data[`PCIPM_CSR_FLAG_BIT];
		enableWrite = wrPmCsr & cfgReq.byteEn[`PCIPM_BYTE_CSR_HIGH];
	end

	pcipm_wake_flag uWake (
		.clock              (clock),
		.sys_rst            (sys_rst),
		.powerOnRst         (powerOnRst),
		.wakeDetect         (wakeDetect & lowPower),
		.flagClear          (flagClear),
		.enableWrite        (enableWrite),
		.enableData         (cfgReq.data[`PCIPM_CSR_ENABLE_BIT]),
		.wake_event_flag    (wakeFlag),
		.wake_notify_enable (wakeEnable),
		.wakeOut            (wakeOut)
	);

	// ============================================================
	// Writable state
	// ============================================================
	logic [7:0]                    intLine;
	logic [HINT_WIDTH-1:0]         maxLatency;
	logic [HINT_WIDTH-1:0]         minGrant;
	logic [7:0]                    next_intLine;
	logic [HINT_WIDTH-1:0]         next_maxLatency;
	logic [HINT_WIDTH-1:0]         next_minGrant;
	pcipm_pkg::pcipm_power_state_t next_powerState;

	always_comb begin
		next_intLine    = intLine;
		next_maxLatency = maxLatency;
		next_minGrant   = minGrant;
		next_powerState = powerState;
		if (wrBusReq && cfgReq.byteEn[`PCIPM_BYTE_INT_LINE]) begin
			next_intLine = cfgReq.data[7:0];
		end
		if (hintLoad.load) begin
			next_maxLatency = hintLoad.maxLatency;
			next_minGrant   = hintLoad.minGrant;
		end
		if (wrPmCsr && cfgReq.byteEn[`PCIPM_BYTE_CSR_LOW]) begin
			next_powerState = pcipm_pkg::pcipm_power_state_t'(cfgReq.data[1:0]);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			intLine    <= `PCIPM_INT_LINE_RESET;
			maxLatency <= `PCIPM_HINT_RESET;
			minGrant   <= `PCIPM_HINT_RESET;
			powerState <= pcipm_pkg::PCIPM_D0;
		end else begin
			intLine    <= next_intLine;
			maxLatency <= next_maxLatency;
			minGrant   <= next_minGrant;
			powerState <= next_powerState;
		end
	end

	// ============================================================
	// Read words
	// ============================================================
	logic [31:0] busReqWord;
	logic [31:0] capWord;
	logic [31:0] csrWord;

	always_comb begin
		busReqWord = {maxLatency, minGrant, `PCIPM_INT_PIN_VALUE, intLine};
		// Every capability field is a constant or the strap, so writes cannot alter it.
		capWord = {strapLatched,
		           `PCIPM_CAP_WAKE_STATES,
		           `PCIPM_CAP_D2_D1,
		           `PCIPM_CAP_RESERVED, `PCIPM_CAP_DEV_INIT,
		           strapLatched,
		           `PCIPM_CAP_WAKE_CLOCK,
		           `PCIPM_CAP_VERSION,
		           `PCIPM_CAP_NEXT_PTR, `PCIPM_CAP_ID};
		csrWord = {`PCIPM_CSR_POWER_DATA, `PCIPM_CSR_BRIDGE_EXT,
		           wakeFlag,
		           `PCIPM_CSR_REPORT_SCALE, `PCIPM_CSR_REPORT_SEL,
		           wakeEnable,
		           `PCIPM_CSR_RESERVED,
		           powerState};
	end

	// ============================================================
	// Read response
	// ============================================================
	pcipm_pkg::pcipm_cfg_rsp_t next_cfgRsp;

	always_comb begin
		next_cfgRsp.valid = cfgReq.read;
		next_cfgRsp.data  = 32'h0000_0000;
		if (cfgReq.read) begin
			unique case (1'b1)
				hitBusReq: next_cfgRsp.data = busReqWord;
				hitPmCap:  next_cfgRsp.data = capWord;
				hitPmCsr:  next_cfgRsp.data = csrWord;
				default:   next_cfgRsp.data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfgRsp <= '0;
		end else begin
			cfgRsp <= next_cfgRsp;
		end
	end

	// ============================================================
	// Checks
	// ============================================================
	// Either reset parks every property, so only settled register traffic is judged.
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || powerOnRst);

	sequence capRead;
		cfgReq.read && hitPmCap;
	endsequence

	sequence csrOneWrite;
		wrPmCsr && cfgReq.byteEn[1] && cfgReq.data[15] && !(wakeDetect && lowPower);
	endsequence

	chk_int_pin_const: assert property (
		cfgReq.read && hitBusReq |=> cfgRsp.valid && cfgRsp.data[15:8] == 8'h01)
		else $error("interrupt pin byte not 01h");

	chk_int_line_store: assert property (
		wrBusReq && cfgReq.byteEn[0] |=> intLine == $past(cfgReq.data[7:0]))
		else $error("interrupt line byte not stored");

	chk_hint_load: assert property (
		hintLoad.load |=> maxLatency == $past(hintLoad.maxLatency)
		&& minGrant == $past(hintLoad.minGrant))
		else $error("hint values not loaded");

	chk_cap_const: assert property (
		capRead |=> cfgRsp.data[30:21] == 10'h3b1 && cfgRsp.data[19:0] == 20'h10001)
		else $error("capabilities constant fields wrong");

	chk_cap_strap: assert property (
		capRead |=> cfgRsp.data[31] == $past(strapLatched)
		&& cfgRsp.data[20] == $past(strapLatched))
		else $error("strap bits disagree");

	chk_csr_zero: assert property (
		cfgReq.read && hitPmCsr
		|=> cfgRsp.data[31:16] == 16'h0000 && cfgRsp.data[14:9] == 6'h00
		&& cfgRsp.data[7:2] == 6'h00)
		else $error("control/status constant bits nonzero");

	chk_flag_set: assert property (
		wakeDetect && lowPower |=> wakeFlag)
		else $error("wake flag did not set");

	chk_flag_clear: assert property (
		csrOneWrite |=> !wakeFlag)
		else $error("wake flag not cleared by one");

	chk_flag_hold: assert property (
		wakeFlag && !flagClear |=> wakeFlag)
		else $error("wake flag lost without clear");

	chk_enable_write: assert property (
		enableWrite |=> wakeEnable == $past(cfgReq.data[8]))
		else $error("enable not written");

	chk_power_state: assert property (
		wrPmCsr && cfgReq.byteEn[0] |=> powerState == $past(cfgReq.data[1:0]))
		else $error("power state not written");

	chk_wake_gate: assert property (
		wakeOut == (wakeFlag && wakeEnable))
		else $error("wake output not flag and enable");

	chk_unmapped_zero: assert property (
		cfgReq.read && !hitBusReq && !hitPmCap && !hitPmCsr |=> cfgRsp.data == 32'h0)
		else $error("unmapped read not zero");

	chk_int_line_read: assert property (
		cfgReq.read && hitBusReq |=> cfgRsp.data[7:0] == $past(intLine)
		&& cfgRsp.data[31:24] == $past(maxLatency))
		else $error("bus requirements word read wrong");

	chk_line_hold: assert property (
		!(wrBusReq && cfgReq.byteEn[0]) |=> $stable(intLine))
		else $error("interrupt line changed without write");

	chk_state_hold: assert property (
		!(wrPmCsr && cfgReq.byteEn[0]) |=> $stable(powerState))
		else $error("power state changed without write");

	chk_enable_hold: assert property (
		!enableWrite |=> $stable(wakeEnable))
		else $error("enable changed without write");

	chk_no_wake_d0: assert property (
		!wakeFlag && !(wakeDetect && lowPower) |=> !wakeFlag)
		else $error("wake flag set without event in low power");

	chk_csr_read: assert property (
		cfgReq.read && hitPmCsr |=> cfgRsp.data[1:0] == $past(powerState)
		&& cfgRsp.data[15] == $past(wakeFlag)
		&& cfgRsp.data[8] == $past(wakeEnable))
		else $error("control/status read wrong");

	chk_rsp_pulse: assert property (
		!cfgReq.read |=> !cfgRsp.valid && cfgRsp.data == 32'h0000_0000)
		else $error("response stood without a read");

endmodule

/* tb/pcipm_host_model.sv */
`timescale 1ns/1ps

// ============================================================
// Host bridge issuing configuration cycles
// ============================================================
module pcipm_host_model (
	// Clock
	input  wire logic                      clock,
	// Configuration access
	output pcipm_pkg::pcipm_cfg_req_t      cfgReq,
	input  wire pcipm_pkg::pcipm_cfg_rsp_t cfgRsp
);
	initial begin
		cfgReq = '0;
	end

	// Released address, enable and data lines show the inverse of their last value, so stale data cannot match.
	task automatic release_bus();
		cfgReq <= '{read: 1'b0, write: 1'b0, addr: ~cfgReq.addr,
			byteEn: ~cfgReq.byteEn, data: ~cfgReq.data};
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clock);
		cfgReq <= '{read: 1'b0, write: 1'b1, addr: a, byteEn: be, data: d};
		@(posedge clock);
		release_bus();
	endtask

	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic ok);
		int i;
		ok = 1'b0;
		d = 32'h0;
		@(posedge clock);
		cfgReq <= '{read: 1'b1, write: 1'b0, addr: a, byteEn: 4'hf, data: cfgReq.data};
		@(posedge clock);
		release_bus();
		for (i = 0; i < 4 && !ok; i++) begin
			#1;
			if (cfgRsp.valid === 1'b1) begin
				ok = 1'b1;
				d = cfgRsp.data;
			end else begin
				@(posedge clock);
			end
		end
	endtask
endmodule

/* tb/pci_power_mgmt_capability_test.sv */
`timescale 1ns/1ps

module pci_power_mgmt_capability_test;
	typedef struct packed {
		logic [7:0]  addr;
		logic [3:0]  byteEn;
		logic [31:0] wdata;
		logic [31:0] expData;
	} pcipm_row_t;

	logic                            clock;
	logic                            sys_rst;
	logic                            powerOnRst;
	logic                            board_aux_power_strap;
	logic                            wakeDetect;
	logic                            wakeOut;
	pcipm_pkg::pcipm_cfg_req_t       cfgReq;
	pcipm_pkg::pcipm_cfg_rsp_t       cfgRsp;
	pcipm_pkg::pcipm_hint_load_t     hintLoad;
	pcipm_pkg::pcipm_power_state_t   powerState;
	int                              errCount;
	int                              nCompared;
	logic [31:0]                     rdData;
	logic                            rdOk;
	pcipm_row_t                      rows [8];

	pcipm_config_regs pcipm_config_regs_inst (
		.clock                 (clock),
		.sys_rst               (sys_rst),
		.powerOnRst            (powerOnRst),
		.cfgReq                (cfgReq),
		.cfgRsp                (cfgRsp),
		.hintLoad              (hintLoad),
		.board_aux_power_strap (board_aux_power_strap),
		.wakeDetect            (wakeDetect),
		.wakeOut               (wakeOut),
		.powerState            (powerState)
	);

	pcipm_host_model pcipm_host_model_inst (
		.clock  (clock),
		.cfgReq (cfgReq),
		.cfgRsp (cfgRsp)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ============================================================
	// Shared tasks
	// ============================================================
	task automatic stopTest();
		$display("Compared %0d, mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("BAD t=%0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		pcipm_host_model_inst.cfg_write(a, be, d);
	endtask

	task automatic rd(input logic [7:0] a);
		pcipm_host_model_inst.cfg_read(a, rdData, rdOk);
		if (!rdOk) begin
			errCount++;
			$display("BAD t=%0t no read answer", $time);
			stopTest();
		end
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		errCount++;
		$display("BAD t=%0t run timed out", $time);
		stopTest();
	end

	// ============================================================
	// Main sequence
	// ============================================================
	initial begin
		errCount = 0;
		nCompared = 0;
		sys_rst = 1'b1;
		powerOnRst = 1'b1;
		board_aux_power_strap = 1'b1;
		wakeDetect = 1'b0;
		hintLoad = '0;
		rows[0] = '{8'h3c, 4'hf, 32'hffffffff, 32'h1c0801ff};
		rows[1] = '{8'h3c, 4'he, 32'h00000000, 32'h1c0801ff};
		rows[2] = '{8'hdc, 4'hf, 32'h00000000, 32'hf6310001};
		rows[3] = '{8'he0, 4'hf, 32'hffffffff, 32'h00000103};
		rows[4] = '{8'he0, 4'h1, 32'h00000001, 32'h00000101};
		rows[5] = '{8'he0, 4'h1, 32'h00000002, 32'h00000102};
		rows[6] = '{8'he0, 4'h3, 32'h00000000, 32'h00000000};
		rows[7] = '{8'h40, 4'hf, 32'h12345678, 32'h00000000};
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		powerOnRst <= 1'b0;
		rd(8'h3c);
		check(rdData, 32'h00000100, "bus word after reset");
		check({30'h0, powerState}, 32'h0, "state after reset");
		@(posedge clock);
		hintLoad <= '{load: 1'b1, maxLatency: 8'h1c, minGrant: 8'h08};
		@(posedge clock);
		hintLoad <= '0;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			wr(rows[i].addr, rows[i].byteEn, rows[i].wdata);
			rd(rows[i].addr);
			check(rdData, rows[i].expData, "table row");
			if (rows[i].addr == 8'he0) begin
				check({30'h0, powerState}, rows[i].expData & 32'h3, "state port");
			end
		end

		// Wake flag in D3: set by an event, survives a zero write, cleared by a one.
		wr(8'he0, 4'h3, 32'h00000003);
		@(posedge clock);
		wakeDetect <= 1'b1;
		@(posedge clock);
		wakeDetect <= 1'b0;
		rd(8'he0);
		check(rdData, 32'h00008003, "flag set");
		check({31'h0, wakeOut}, 32'h0, "wake out without enable");
		wr(8'he0, 4'h2, 32'h00000100);
		rd(8'he0);
		check(rdData, 32'h00008103, "flag kept on zero write");
		check({31'h0, wakeOut}, 32'h1, "wake out with enable");
		wr(8'he0, 4'h2, 32'h00008100);
		rd(8'he0);
		check(rdData, 32'h00000103, "flag cleared by one");
		check({31'h0, wakeOut}, 32'h0, "wake out after clear");

		// System reset in mid-run.
		wr(8'h3c, 4'h1, 32'h000000ff);
		@(posedge clock);
		sys_rst <= 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		rd(8'h3c);
		check(rdData, 32'h00000100, "line byte after reset");
		// An event while in D0 must not set the flag.
		@(posedge clock);
		wakeDetect <= 1'b1;
		@(posedge clock);
		wakeDetect <= 1'b0;
		rd(8'he0);
		check(rdData, 32'h00000000, "control word after reset");
		check({31'h0, wakeOut}, 32'h0, "wake out in D0");
		check({30'h0, powerState}, 32'h0, "state after second reset");

		// Power-up with the strap low.
		@(posedge clock);
		board_aux_power_strap <= 1'b0;
		powerOnRst <= 1'b1;
		repeat (2) @(posedge clock);
		powerOnRst <= 1'b0;
		repeat (6) @(posedge clock);
		rd(8'hdc);
		check(rdData, 32'h76210001, "capabilities, strap low");
		stopTest();
	end
endmodule
